/* core/aphp_port.sv */
/*
  Assisted parallel host port: an AXI4-Lite register slave plus the
  handshaked 8/16/24-bit parallel data port towards an external master.
  Assumes data pins are synchronous to aclk and held stable by the
  external party while its strobe is low; handshake inputs are async.
*/
// Behaviour
// - Transfer width 8, 16 or 24 bits by config
// - Enabled port owns pins; handshake outputs push-pull
// - Drive input-room output pin
// - Drive output-available output pin
// - Strobe latches input, output-enable presents output
// - Strobe and output-enable act only under chip-select
// - Port0 write sets data-ready until output enable
// - Port0 read sets latch-empty until strobe
// - Data-ready polarity bit; status reads opposite pin while enabled
// - Latch-empty polarity bit; status reads opposite pin while enabled
// - Only port0 write raises data ready
// - Output enable plus chip-select drives output word
// - Output enable release raises read-done interrupt
// - Strobe plus chip-select captures data, latches full
// - Strobe release raises write-done interrupt
// - Only port0 read raises latch empty
`timescale 1ns/1ps
module aphp_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire aphp_pkg::aphp_hs_in_t hs_in,
  output aphp_pkg::aphp_hs_out_t hs_out,
  input wire logic [23:0] data_in,
  output logic [23:0] data_out,
  output logic [23:0] data_oe_n,
  output logic irq
);

  // Configuration and transfer state
  logic [1:0] width;
  logic out_pol;
  logic in_pol;
  logic enable;
  logic out_avail;
  logic in_room;
  logic [23:0] out_latch;
  logic [23:0] in_latch;

  // Write channel capture
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Synchronised handshake inputs and their last-cycle activity
  aphp_pkg::aphp_hs_in_t hs_s;
  logic wr_act_q;
  logic rd_act_q;

  logic [aphp_pkg::IRQ_COUNT-1:0] irq_status;
  logic [aphp_pkg::IRQ_COUNT-1:0] irq_mask;

  aphp_sync #(
    .WIDTH(3),
    .INIT(aphp_pkg::SYNC_RESET)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(hs_in),
    .dout(hs_s)
  );

  // Pin-side activity, gated by chip-select and the port enable
  wire wr_act = enable & ~hs_s.chip_sel_n & ~hs_s.write_strobe_n;
  wire rd_act = enable & ~hs_s.chip_sel_n & ~hs_s.out_enable_n;
  wire wr_start = wr_act & ~wr_act_q;
  wire wr_end = wr_act_q & ~wr_act;
  wire rd_start = rd_act & ~rd_act_q;
  wire rd_end = rd_act_q & ~rd_act;

  wire [23:0] lanes = aphp_pkg::lane_mask(width);

  // Bus handshakes
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire do_wr = aw_got & w_got & ~s_axi_bvalid;
  wire lane0_we = do_wr & w_strb[0];

  assign s_axi_awready = ~aw_got;
  assign s_axi_wready = ~w_got;
  assign s_axi_arready = ~s_axi_rvalid;

  // Write address decode
  wire wr_cfg = lane0_we & (aw_addr == aphp_pkg::CFG_OFS);
  wire wr_p0 = lane0_we & (aw_addr == aphp_pkg::PORT0_OFS);
  wire wr_p1 = lane0_we & (aw_addr == aphp_pkg::PORT1_OFS);
  wire wr_p2 = lane0_we & (aw_addr == aphp_pkg::PORT2_OFS);
  wire wr_stat = lane0_we & (aw_addr == aphp_pkg::IRQ_STAT_OFS);
  wire wr_mask = lane0_we & (aw_addr == aphp_pkg::IRQ_MASK_OFS);
  wire wr_hit = (aw_addr == aphp_pkg::CFG_OFS) | (aw_addr == aphp_pkg::PORT0_OFS)
    | (aw_addr == aphp_pkg::PORT1_OFS) | (aw_addr == aphp_pkg::PORT2_OFS)
    | (aw_addr == aphp_pkg::IRQ_STAT_OFS) | (aw_addr == aphp_pkg::IRQ_MASK_OFS);

  // Read address decode
  wire rd_p0 = ar_take & (s_axi_araddr == aphp_pkg::PORT0_OFS);

  // Status bits read opposite to their pins while the port is enabled
  wire out_avail_bit = out_pol ? out_avail : ~out_avail;
  wire in_room_bit = in_pol ? in_room : ~in_room;

  wire [7:0] cfg_rd = {1'b0, enable, in_pol, out_pol, in_room_bit, out_avail_bit, width};

  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      aphp_pkg::CFG_OFS: rd_mux = {24'h000000, cfg_rd};
      aphp_pkg::PORT0_OFS: rd_mux = {24'h000000, in_latch[7:0]};
      aphp_pkg::PORT1_OFS: rd_mux = {24'h000000, in_latch[15:8]};
      aphp_pkg::PORT2_OFS: rd_mux = {24'h000000, in_latch[23:16]};
      aphp_pkg::IRQ_STAT_OFS: rd_mux = {30'h0, irq_status};
      aphp_pkg::IRQ_MASK_OFS: rd_mux = {30'h0, irq_mask};
      default:
      begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Flag updates: the firmware set wins over a same-cycle pin clear
  wire next_out_avail = wr_p0 | (out_avail & ~rd_start);
  wire next_in_room = rd_p0 | (in_room & ~wr_start);

  // Captured input word, only lanes in use, while strobe is active
  wire [23:0] next_in_latch = wr_act ? ((in_latch & ~lanes) | (data_in & lanes))
    : in_latch;

  // Output word loaded byte by byte from firmware writes
  wire [23:0] next_out_latch = {
    wr_p2 ? w_data[7:0] : out_latch[23:16],
    wr_p1 ? w_data[7:0] : out_latch[15:8],
    wr_p0 ? w_data[7:0] : out_latch[7:0]
  };

  // Drive the data pins only while the external read is active
  wire [23:0] next_data_oe_n = rd_act ? ~lanes : 24'hffffff;

  aphp_irq #(
    .N(aphp_pkg::IRQ_COUNT)
  ) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .set({wr_end, rd_end}),
    .clr(wr_stat ? w_data[aphp_pkg::IRQ_COUNT-1:0] : 2'h0),
    .mask_we(wr_mask),
    .mask_wdata(w_data[aphp_pkg::IRQ_COUNT-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // Handshake outputs, push-pull while enabled, low otherwise
  assign hs_out.output_avail_pin = enable & ~out_avail_bit;
  assign hs_out.input_room_pin = enable & ~in_room_bit;

  // Write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (aw_take)
        aw_addr <= s_axi_awaddr;
      if (w_take)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_got <= do_wr ? 1'b0 : (aw_got | aw_take);
      w_got <= do_wr ? 1'b0 : (w_got | w_take);
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= aphp_pkg::RESP_OKAY;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? aphp_pkg::RESP_OKAY : aphp_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= aphp_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? aphp_pkg::RESP_OKAY : aphp_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Configuration
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      width <= aphp_pkg::WIDTH_RESET;
      out_pol <= aphp_pkg::POL_RESET;
      in_pol <= aphp_pkg::POL_RESET;
      enable <= aphp_pkg::ENABLE_RESET;
    end
    else if (wr_cfg)
    begin
      width <= w_data[aphp_pkg::CFG_WIDTH_LSB +: 2];
      out_pol <= w_data[aphp_pkg::CFG_OUT_POL_BIT];
      in_pol <= w_data[aphp_pkg::CFG_IN_POL_BIT];
      enable <= w_data[aphp_pkg::CFG_ENABLE_BIT];
    end
  end

  // Transfer state and pin drive
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_avail <= aphp_pkg::OUT_AVAIL_RESET;
      in_room <= aphp_pkg::IN_ROOM_RESET;
      out_latch <= aphp_pkg::LATCH_RESET;
      in_latch <= aphp_pkg::LATCH_RESET;
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      data_out <= aphp_pkg::LATCH_RESET;
      data_oe_n <= 24'hffffff;
    end
    else
    begin
      out_avail <= next_out_avail;
      in_room <= next_in_room;
      out_latch <= next_out_latch;
      in_latch <= next_in_latch;
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      data_out <= out_latch;
      data_oe_n <= next_data_oe_n;
    end
  end

endmodule : aphp_port

/* core/aphp_pkg.sv */
/*
  Shared constants and types of the assisted parallel host port:
  register offsets, field positions, reset values and pin groups.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package aphp_pkg;

  // Register byte offsets
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] PORT0_OFS = 8'h04;
  localparam logic [7:0] PORT1_OFS = 8'h08;
  localparam logic [7:0] PORT2_OFS = 8'h0c;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

  // Configuration register fields
  localparam int CFG_WIDTH_LSB = 0;
  localparam int CFG_OUT_AVAIL_BIT = 2;
  localparam int CFG_IN_ROOM_BIT = 3;
  localparam int CFG_OUT_POL_BIT = 4;
  localparam int CFG_IN_POL_BIT = 5;
  localparam int CFG_ENABLE_BIT = 6;

  // Transfer width codes
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_24 = 2'h2;

  // Interrupt status bits
  localparam int IRQ_READ_DONE = 0;
  localparam int IRQ_WRITE_DONE = 1;
  localparam int IRQ_COUNT = 2;

  // Reset values
  localparam logic [1:0] WIDTH_RESET = 2'h0;
  localparam logic POL_RESET = 1'b0;
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic OUT_AVAIL_RESET = 1'b0;
  localparam logic IN_ROOM_RESET = 1'b1;
  localparam logic [23:0] LATCH_RESET = 24'h000000;
  localparam logic [2:0] SYNC_RESET = 3'h7;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Handshake inputs from the external party, all active low
  typedef struct packed {
    logic chip_sel_n;
    logic out_enable_n;
    logic write_strobe_n;
  } aphp_hs_in_t;

  // Handshake outputs towards the external party
  typedef struct packed {
    logic output_avail_pin;
    logic input_room_pin;
  } aphp_hs_out_t;

  // Byte lanes that take part in a transfer of the given width
  function automatic logic [23:0] lane_mask(input logic [1:0] width);
    case (width)
      WIDTH_8: lane_mask = 24'h0000ff;
      WIDTH_16: lane_mask = 24'h00ffff;
      default: lane_mask = 24'hffffff;
    endcase
  endfunction : lane_mask

endpackage : aphp_pkg

/* core/aphp_sync.sv */
/*
  Two-stage synchroniser for a group of level inputs.
  Assumes the inputs may change at any time relative to aclk.
*/
`timescale 1ns/1ps
module aphp_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= INIT;
      dout <= INIT;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : aphp_sync

/* core/aphp_irq.sv */
/*
  Sticky interrupt status with write-one-to-clear, a mask and one
  level interrupt output. Assumes set pulses are one cycle wide.
*/
`timescale 1ns/1ps
module aphp_irq #(
  parameter int N = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  input wire logic mask_we,
  input wire logic [N-1:0] mask_wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);
  // A set in the same cycle as its clear wins
  wire [N-1:0] next_status = (status & ~clr) | set;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status <= '0;
      mask <= '0;
    end
    else
    begin
      status <= next_status;
      if (mask_we)
        mask <= mask_wdata;
    end
  end

  assign irq = |(status & mask);
endmodule : aphp_irq

/* testbench/aphp_port_props.sv */
/*
  Concurrent checks on the pins of the parallel host port.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module aphp_port_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire aphp_pkg::aphp_hs_in_t hs_in,
  input wire logic [23:0] data_oe_n,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire rd_req = !hs_in.out_enable_n && !hs_in.chip_sel_n;
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_b_cause: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
    else $error("write response without request");
  a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("read data late");
  a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_drive_cause: assert property (data_oe_n != 24'hffffff |-> $past(rd_req, 2)
    || $past(rd_req, 3)) else $error("data driven without read request");
  a_cs_gate: assert property (hs_in.chip_sel_n [*5] |-> data_oe_n == 24'hffffff)
    else $error("data driven while deselected");
  a_lane_shape: assert property (data_oe_n inside {24'hffffff, 24'hffff00,
    24'hff0000, 24'h000000}) else $error("data lanes not a legal width");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_drive: cover property (data_oe_n == 24'h000000);
  c_irq: cover property ($rose(irq));
endmodule : aphp_port_props

bind aphp_port aphp_port_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .hs_in(hs_in),
  .data_oe_n(data_oe_n), .irq(irq));

/* testbench/aphp_ext_model.sv */
/*
  Behavioural external master on the parallel side of the port.
  Assumes its tasks are called just after a rising edge of aclk.
*/
`timescale 1ns/1ps
module aphp_ext_model (
  input wire logic aclk,
  output aphp_pkg::aphp_hs_in_t hs_in,
  output logic [23:0] data_in,
  input wire logic [23:0] data_out,
  input wire logic [23:0] data_oe_n
);
  initial
  begin
    hs_in = 3'h7;
    data_in = 24'h000000;
  end
  // Strobe a word in; sel low keeps chip select idle
  task automatic put(input logic [23:0] d, input logic sel);
    @(posedge aclk);
    data_in <= d;
    hs_in <= {~sel, 1'b1, 1'b0};
    repeat (4) @(posedge aclk);
    hs_in <= 3'h7;
    repeat (3) @(posedge aclk);
    data_in <= ~d; // Released bus shows no stale value
  endtask : put
  // Read a word; returns it with the lane enables seen
  task automatic get(output logic [23:0] d, output logic [23:0] oe);
    int n;
    n = 0;
    @(posedge aclk);
    hs_in <= 3'h1;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (data_oe_n[7:0] !== 8'h00 && n < 12);
    d = data_out;
    oe = data_oe_n;
    hs_in <= 3'h7;
  endtask : get
endmodule : aphp_ext_model

/* testbench/tb.sv */
/*
  Self-checking bench: register traffic over AXI4-Lite and parallel
  transfers by the external master model.
  Assumes the design answers every bus request before the cycle ceiling.
*/
`timescale 1ns/1ps
`define CHK(n, a, e) \
  begin \
    checks++; \
    if ((a) !== (e)) \
    begin \
      mismatches++; \
      $display("[ERR] %s expected %h seen %h", n, e, a); \
    end \
  end
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  aphp_pkg::aphp_hs_in_t hs_in;
  aphp_pkg::aphp_hs_out_t hs_out;
  logic [23:0] data_in, data_out, data_oe_n, ro, roe, rw, xe;
  int mismatches = 0, checks = 0, cyc = 0;
  always #2.5 aclk = ~aclk;
  aphp_port u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .hs_in(hs_in), .hs_out(hs_out), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .irq(irq)
  );
  aphp_ext_model u_ext (
    .aclk(aclk), .hs_in(hs_in), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n)
  );
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    `CHK("bvalid", s_axi_bvalid, 1'b1);
    `CHK("bresp", s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    `CHK("rdata", s_axi_rdata, {24'h000000, e});
    `CHK("rresp", s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axr
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("pins idle", hs_out, 2'b00);
    axr(aphp_pkg::CFG_OFS, 8'h04, aphp_pkg::RESP_OKAY);
    axr(8'h18, 8'h00, aphp_pkg::RESP_SLVERR);
    axw(8'h18, 8'hff, aphp_pkg::RESP_SLVERR);
    axw(aphp_pkg::IRQ_MASK_OFS, 8'h01, aphp_pkg::RESP_OKAY);
    axr(aphp_pkg::IRQ_MASK_OFS, 8'h01, aphp_pkg::RESP_OKAY);
    // Width code 3 is run as well and must behave as 24 bits
    for (int i = 0; i < 4; i++)
    begin
      rw = i == 0 ? 24'hffff00 : (i == 1 ? 24'hff0000 : 24'h000000);
      xe = 24'(24'h302010 + 24'h010101 * i);
      axw(aphp_pkg::CFG_OFS, {6'h10, i[1:0]}, aphp_pkg::RESP_OKAY);
      axw(aphp_pkg::PORT2_OFS, xe[23:16], aphp_pkg::RESP_OKAY);
      axw(aphp_pkg::PORT1_OFS, xe[15:8], aphp_pkg::RESP_OKAY);
      `CHK("avail early", hs_out, 2'b01);
      axw(aphp_pkg::PORT0_OFS, xe[7:0], aphp_pkg::RESP_OKAY);
      `CHK("avail", hs_out, 2'b11);
      axr(aphp_pkg::CFG_OFS, {6'h10, i[1:0]}, aphp_pkg::RESP_OKAY);
      u_ext.get(ro, roe);
      `CHK("lanes", roe, rw);
      `CHK("word", ro | rw, xe | rw);
      repeat (5) @(posedge aclk);
      `CHK("irq read", irq, 1'b1);
      `CHK("avail done", hs_out, 2'b01);
      axr(aphp_pkg::IRQ_STAT_OFS, 8'h01, aphp_pkg::RESP_OKAY);
      axw(aphp_pkg::IRQ_STAT_OFS, 8'h01, aphp_pkg::RESP_OKAY);
      `CHK("irq clear", irq, 1'b0);
    end
    u_ext.put(24'ha5b6c7, 1'b1);
    repeat (2) @(posedge aclk);
    `CHK("room", hs_out, 2'b00);
    `CHK("irq masked", irq, 1'b0);
    axr(aphp_pkg::IRQ_STAT_OFS, 8'h02, aphp_pkg::RESP_OKAY);
    axr(aphp_pkg::PORT2_OFS, 8'ha5, aphp_pkg::RESP_OKAY);
    axr(aphp_pkg::PORT1_OFS, 8'hb6, aphp_pkg::RESP_OKAY);
    `CHK("room early", hs_out, 2'b00);
    axr(aphp_pkg::PORT0_OFS, 8'hc7, aphp_pkg::RESP_OKAY);
    `CHK("room back", hs_out, 2'b01);
    axw(aphp_pkg::IRQ_MASK_OFS, 8'h03, aphp_pkg::RESP_OKAY);
    `CHK("irq unmask", irq, 1'b1);
    axw(aphp_pkg::IRQ_STAT_OFS, 8'h02, aphp_pkg::RESP_OKAY);
    `CHK("irq off", irq, 1'b0);
    u_ext.put(24'h123456, 1'b0);
    repeat (2) @(posedge aclk);
    `CHK("no select", hs_out, 2'b01);
    axr(aphp_pkg::IRQ_STAT_OFS, 8'h00, aphp_pkg::RESP_OKAY);
    axr(aphp_pkg::PORT2_OFS, 8'ha5, aphp_pkg::RESP_OKAY);
    axw(aphp_pkg::CFG_OFS, 8'h72, aphp_pkg::RESP_OKAY);
    `CHK("pins inverted", hs_out, 2'b10);
    // A write without byte lane 0 must leave the configuration alone
    s_axi_wstrb <= 4'h0;
    axw(aphp_pkg::CFG_OFS, 8'h00, aphp_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    axr(aphp_pkg::CFG_OFS, 8'h7a, aphp_pkg::RESP_OKAY);
    // Reset in mid-run returns every register to its idle default
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("pins reset", hs_out, 2'b00);
    `CHK("irq reset", irq, 1'b0);
    axr(aphp_pkg::CFG_OFS, 8'h04, aphp_pkg::RESP_OKAY);
    axr(aphp_pkg::IRQ_MASK_OFS, 8'h00, aphp_pkg::RESP_OKAY);
    print_verdict();
  end
endmodule : tb
